// File: core/wdtit_params.svh
// Constants for the watchdog / interval timer: offsets, keys, resets, timing
`ifndef WDTIT_PARAMS_SVH
`define WDTIT_PARAMS_SVH

// Word indices on the register bus; byte address is four times the index
`define WDTIT_IDX_COUNT 2'h0
`define WDTIT_IDX_CTRL 2'h1
`define WDTIT_IDX_RSTCTRL 2'h2

// Upper-byte keys that make a word write take effect
`define WDTIT_KEY_COUNT 8'h5a
`define WDTIT_KEY_CTRL 8'ha5
`define WDTIT_KEY_CHIP_RESET_ENABLE 8'h5a
`define WDTIT_KEY_WATCHDOG_OVERFLOW_FLAG 8'ha5

// Field positions in the low data byte
`define WDTIT_BIT_OVF 7
`define WDTIT_BIT_MODE 6
`define WDTIT_BIT_RUN 5
`define WDTIT_BIT_CHIP_RESET_ENABLE 6
`define WDTIT_BIT_SPARE 5

// Reset values
`define WDTIT_COUNT_RST 8'h00
`define WDTIT_RSTCTRL_RST 8'h1f
`define WDTIT_CTRL_ONES 2'h3
`define WDTIT_RSTCTRL_ONES 5'h1f

// Pulse lengths in system clock states
`define WDTIT_PIN_LEN_CHIP_RESET_ENABLE 8'd132
`define WDTIT_PIN_LEN_NORST 8'd130
`define WDTIT_CHIPRST_LEN 10'd518

`endif

// File: core/wdtit_pkg.sv
// Types shared by the watchdog / interval timer
package wdtit_pkg;

    typedef enum logic
    {
        WDTIT_MODE_INTERVAL = 1'b0,
        WDTIT_MODE_WATCHDOG = 1'b1
    } wdtit_mode_type;

    typedef struct packed
    {
        logic ovf;
        wdtit_mode_type mode;
        logic run;
        logic [2:0] cks;
    } wdtit_ctrl_type;

    typedef struct packed
    {
        logic watchdog_overflow_flag;
        logic chip_reset_enable;
        logic spare;
    } wdtit_rstctrl_type;

endpackage : wdtit_pkg

// File: core/wdtit_top.sv
// Watchdog / interval timer with Avalon-MM register slave
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "wdtit_params.svh"

// Functional notes
// - An 8-bit up-counter that software can read and write.
// - Run enable starts counting; clearing it stops and zeroes the counter.
// - Control bit 6 selects interval (0) or watchdog (1) operation.
// - Interval mode: wrap from ff to 00 sets the overflow flag.
// - Interval mode: each overflow raises the interval interrupt request.
// - Watchdog mode: overflow drives the active-low overflow pin.
// - Overflow flag clears by writing 0 only after reading it as one.
// - Internal reset from watchdog overflow clears the overflow flag.
// - Clock select picks system clock divided by 2 up to 131072.
// - Reserved bits read as one and ignore writes.
// - Reset control register resets to 1f only on the external reset.
// - Watchdog flag sets on overflow in watchdog mode only.
// - Watchdog flag clears by writing 0 after reading it as one.
// - Chip reset enable makes watchdog overflow reset the whole chip.
// - Without chip reset, overflow resets only counter and control register.
// - Reset control bit 5 is plain storage, reset zero, no effect.
// - Pin low 132 states with chip reset, else 130; reset 518 states.
// - While pin low, writes ignored and watchdog flag reads not counted.
module wdtit_top
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic overflow_out_n,
    output logic interval_irq,
    output logic chip_reset_out
);
    import wdtit_pkg::*;

    wdtit_ctrl_type ctrl_q;
    wdtit_rstctrl_type rstctrl_q;
    logic [7:0] timer_counter_q;
    logic [16:0] prescale_q;
    logic waitreq_q;
    logic [31:0] readdata_q;
    logic ovf_armed_q;
    logic watchdog_overflow_flag_armed_q;
    logic overflow_out_n_q;
    logic [7:0] pin_cnt_q;
    logic chip_reset_q;
    logic [9:0] chiprst_cnt_q;
    logic interval_irq_q;
    logic ovf_d;
    logic tick;
    logic access;
    logic wr_ok;
    logic count_wr;
    logic ctrl_wr;
    logic chip_reset_enable_wr;
    logic watchdog_overflow_flag_clr;
    logic ctrl_rd;
    logic rstctrl_rd;
    logic ovf_event;
    logic wd_event;
    logic it_event;
    logic [7:0] ctrl_byte;
    logic [7:0] rstctrl_byte;

    // Tap of the prescaler that gives division by 2, 64 ... 131072
    function automatic logic tap_tick(input logic [2:0] sel, input logic [16:0] pre);
        logic t;
        t = 1'b0;
        unique case (sel)
            3'h0: t = pre[0];
            3'h1: t = &pre[5:0];
            3'h2: t = &pre[6:0];
            3'h3: t = &pre[8:0];
            3'h4: t = &pre[10:0];
            3'h5: t = &pre[12:0];
            3'h6: t = &pre[14:0];
            3'h7: t = &pre[16:0];
        endcase
        return t;
    endfunction

    assign tick = tap_tick(ctrl_q.cks, prescale_q);
    assign ctrl_byte = {ctrl_q.ovf, ctrl_q.mode, ctrl_q.run, `WDTIT_CTRL_ONES, ctrl_q.cks};
    assign rstctrl_byte = {rstctrl_q.watchdog_overflow_flag, rstctrl_q.chip_reset_enable, rstctrl_q.spare,
        `WDTIT_RSTCTRL_ONES};

    // Bus access completes on the edge where waitrequest is seen low
    assign access = clk_en && (avs_read || avs_write) && !waitreq_q;
    // Byte writes are dropped; the key byte guards against runaway stores
    assign wr_ok = access && avs_write && (avs_byteenable[1:0] == 2'h3)
        && overflow_out_n_q;
    assign count_wr = wr_ok && avs_address == `WDTIT_IDX_COUNT
        && avs_writedata[15:8] == `WDTIT_KEY_COUNT;
    assign ctrl_wr = wr_ok && avs_address == `WDTIT_IDX_CTRL
        && avs_writedata[15:8] == `WDTIT_KEY_CTRL;
    assign chip_reset_enable_wr = wr_ok && avs_address == `WDTIT_IDX_RSTCTRL
        && avs_writedata[15:8] == `WDTIT_KEY_CHIP_RESET_ENABLE;
    assign watchdog_overflow_flag_clr = wr_ok && avs_address == `WDTIT_IDX_RSTCTRL
        && avs_writedata[15:8] == `WDTIT_KEY_WATCHDOG_OVERFLOW_FLAG && !avs_writedata[`WDTIT_BIT_OVF];
    assign ctrl_rd = access && avs_read && avs_address == `WDTIT_IDX_CTRL;
    assign rstctrl_rd = access && avs_read && avs_address == `WDTIT_IDX_RSTCTRL
        && overflow_out_n_q;

    // A counter write in the same cycle wins over the increment
    assign ovf_event = clk_en && ctrl_q.run && tick && timer_counter_q == 8'hff && !count_wr;
    assign wd_event = ovf_event && ctrl_q.mode == WDTIT_MODE_WATCHDOG;
    assign it_event = ovf_event && ctrl_q.mode == WDTIT_MODE_INTERVAL;

    always_comb
    begin
        ovf_d = ctrl_q.ovf;
        if (it_event)
            ovf_d = 1'b1;
        else if (wd_event)
            ovf_d = 1'b0;
        else if (ctrl_wr && !avs_writedata[`WDTIT_BIT_OVF] && ovf_armed_q)
            ovf_d = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            waitreq_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            waitreq_q <= !((avs_read || avs_write) && waitreq_q);
            if (avs_read && waitreq_q)
            begin
                unique case (avs_address)
                    `WDTIT_IDX_COUNT: readdata_q <= {24'h00_0000, timer_counter_q};
                    `WDTIT_IDX_CTRL: readdata_q <= {24'h00_0000, ctrl_byte};
                    `WDTIT_IDX_RSTCTRL: readdata_q <= {24'h00_0000, rstctrl_byte};
                    default: readdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            prescale_q <= 17'h0_0000;
        else if (clk_en)
        begin
            // Held at zero while stopped so the first interval is exact
            if (!ctrl_q.run)
                prescale_q <= 17'h0_0000;
            else
                prescale_q <= prescale_q + 17'h0_0001;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            timer_counter_q <= `WDTIT_COUNT_RST;
        else if (clk_en)
        begin
            if (wd_event || !ctrl_q.run)
                timer_counter_q <= `WDTIT_COUNT_RST;
            else if (count_wr)
                timer_counter_q <= avs_writedata[7:0];
            else if (tick)
                timer_counter_q <= timer_counter_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_q <= '0;
            ovf_armed_q <= 1'b0;
            interval_irq_q <= 1'b0;
        end
        else if (clk_en)
        begin
            interval_irq_q <= ovf_d;
            ctrl_q.ovf <= ovf_d;
            if (wd_event)
            begin
                // Control register returns to its reset state on watchdog overflow
                ctrl_q.mode <= WDTIT_MODE_INTERVAL;
                ctrl_q.run <= 1'b0;
                ctrl_q.cks <= 3'h0;
                ovf_armed_q <= 1'b0;
            end
            else
            begin
                if (ctrl_wr)
                begin
                    ctrl_q.mode <= wdtit_mode_type'(avs_writedata[`WDTIT_BIT_MODE]);
                    ctrl_q.run <= avs_writedata[`WDTIT_BIT_RUN];
                    ctrl_q.cks <= avs_writedata[2:0];
                end
                // Arm from the byte handed to software, not the live flag, which may have just set
                if (ctrl_wr)
                    ovf_armed_q <= 1'b0;
                else if (ctrl_rd && readdata_q[`WDTIT_BIT_OVF])
                    ovf_armed_q <= 1'b1;
            end
        end
    end

    // Only the external reset touches this register; the chip reset leaves it
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rstctrl_q <= '0;
            watchdog_overflow_flag_armed_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wd_event)
                rstctrl_q.watchdog_overflow_flag <= 1'b1;
            else if (watchdog_overflow_flag_clr && watchdog_overflow_flag_armed_q)
                rstctrl_q.watchdog_overflow_flag <= 1'b0;
            if (chip_reset_enable_wr)
            begin
                rstctrl_q.chip_reset_enable <= avs_writedata[`WDTIT_BIT_CHIP_RESET_ENABLE];
                rstctrl_q.spare <= avs_writedata[`WDTIT_BIT_SPARE];
            end
            if (watchdog_overflow_flag_clr || wd_event)
                watchdog_overflow_flag_armed_q <= 1'b0;
            else if (rstctrl_rd && readdata_q[`WDTIT_BIT_OVF])
                watchdog_overflow_flag_armed_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            overflow_out_n_q <= 1'b1;
            pin_cnt_q <= 8'h00;
        end
        else if (clk_en)
        begin
            if (wd_event)
            begin
                overflow_out_n_q <= 1'b0;
                pin_cnt_q <= rstctrl_q.chip_reset_enable ? `WDTIT_PIN_LEN_CHIP_RESET_ENABLE - 8'd1
                    : `WDTIT_PIN_LEN_NORST - 8'd1;
            end
            else if (pin_cnt_q != 8'h00)
                pin_cnt_q <= pin_cnt_q - 8'h01;
            else
                overflow_out_n_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            chip_reset_q <= 1'b0;
            chiprst_cnt_q <= 10'h000;
        end
        else if (clk_en)
        begin
            if (wd_event && rstctrl_q.chip_reset_enable)
            begin
                chip_reset_q <= 1'b1;
                chiprst_cnt_q <= `WDTIT_CHIPRST_LEN - 10'd1;
            end
            else if (chiprst_cnt_q != 10'h000)
                chiprst_cnt_q <= chiprst_cnt_q - 10'h001;
            else
                chip_reset_q <= 1'b0;
        end
    end

    assign avs_readdata = readdata_q;
    assign avs_waitrequest = waitreq_q;
    assign overflow_out_n = overflow_out_n_q;
    assign interval_irq = interval_irq_q;
    assign chip_reset_out = chip_reset_q;

    // Checking helpers: measured pulse widths and the width expected for the overflow pin
    logic [9:0] pin_low_len_q;
    logic [9:0] chip_len_q;
    logic [9:0] pin_expect_q;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_low_len_q <= 10'h000;
            chip_len_q <= 10'h000;
            pin_expect_q <= 10'h000;
        end
        else if (clk_en)
        begin
            if (wd_event)
                pin_expect_q <= rstctrl_q.chip_reset_enable ? 10'd132 : 10'd130;
            pin_low_len_q <= overflow_out_n_q ? 10'h000 : pin_low_len_q + 10'h001;
            chip_len_q <= chip_reset_q ? chip_len_q + 10'h001 : 10'h000;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence arm_read_s;
        ctrl_rd && avs_readdata[`WDTIT_BIT_OVF] && !wd_event;
    endsequence

    sequence clear_write_s;
        ctrl_wr && !avs_writedata[`WDTIT_BIT_OVF] && !it_event;
    endsequence

    stopped_zero_a: assert property (clk_en && !ctrl_q.run |=> timer_counter_q == 8'h00)
        else $error("counter not zero while stopped");
    ovf_set_a: assert property (it_event |=> ctrl_q.ovf && interval_irq_q)
        else $error("interval overflow did not set flag and request");
    irq_track_a: assert property (interval_irq_q == ctrl_q.ovf)
        else $error("interval request differs from overflow flag");
    ovf_clear_a: assert property (arm_read_s ##1 (!ctrl_wr && !it_event && clk_en)[*2]
        ##1 clear_write_s |=> !ctrl_q.ovf)
        else $error("armed clear did not clear overflow flag");
    ovf_noarm_a: assert property (clear_write_s and (!ovf_armed_q && ctrl_q.ovf
        && !wd_event) |=> ctrl_q.ovf)
        else $error("unarmed write cleared overflow flag");
    watchdog_overflow_flag_set_a: assert property (wd_event |=> rstctrl_q.watchdog_overflow_flag && !overflow_out_n_q
        && !ctrl_q.run && timer_counter_q == 8'h00)
        else $error("watchdog overflow effects missing");
    watchdog_overflow_flag_interval_a: assert property (it_event && !rstctrl_q.watchdog_overflow_flag |=> !rstctrl_q.watchdog_overflow_flag)
        else $error("watchdog flag set in interval mode");
    pin_len_a: assert property ($rose(overflow_out_n_q) |-> pin_low_len_q == pin_expect_q)
        else $error("overflow pin low time wrong");
    chip_len_a: assert property ($fell(chip_reset_q) |-> chip_len_q == 10'd518)
        else $error("internal reset pulse length wrong");
    wr_block_a: assert property (!overflow_out_n_q && access && avs_write
        |=> $stable(rstctrl_q.chip_reset_enable))
        else $error("write accepted while overflow pin low");
    rsvd_ones_a: assert property (!waitreq_q && avs_address == `WDTIT_IDX_CTRL
        && $past(avs_read) |-> avs_readdata[4:3] == 2'h3)
        else $error("reserved control bits not read as one");

endmodule // wdtit_top

// File: dv/wdtit_top_test.sv
// Self-checking bench for the watchdog / interval timer
`timescale 1ns/1ps
module wdtit_top_test;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [1:0] avs_address = 2'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic overflow_out_n;
    logic interval_irq;
    logic chip_reset_out;
    logic [31:0] rd;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;

    wdtit_top i_wdtit_top
    (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .overflow_out_n(overflow_out_n), .interval_irq(interval_irq),
        .chip_reset_out(chip_reset_out)
    );

    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One Avalon access; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [1:0] a, input logic [15:0] d,
                       input logic [3:0] be = 4'hf);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= be;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        check(n, 2);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
        bus(1'b0, a, 16'h0);
        check(rd, {24'h0, exp});
    endtask

    // Waits for the pin (pin=1) or the interrupt (pin=0), bounded
    task automatic wait_ev(input bit pin, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while ((pin ? overflow_out_n : ~interval_irq) !== 1'b0 && n < lim);
        check(32'(n < lim), 32'h1);
    endtask

    task automatic t_regs();
        rchk(2'h1, 8'h18);
        rchk(2'h0, 8'h00);
        rchk(2'h2, 8'h1f);
        rchk(2'h3, 8'h00);
        bus(1'b1, 2'h0, 16'h5a77);
        rchk(2'h0, 8'h00);
        bus(1'b1, 2'h2, 16'h5aff);
        rchk(2'h2, 8'h7f);
        bus(1'b1, 2'h2, 16'h5a00, 4'h1);
        bus(1'b1, 2'h2, 16'h3c00);
        rchk(2'h2, 8'h7f);
        bus(1'b1, 2'h2, 16'h5a00);
        rchk(2'h2, 8'h1f);
        bus(1'b1, 2'h1, 16'ha520, 4'h2);
        rchk(2'h1, 8'h18);
        bus(1'b1, 2'h1, 16'ha5ff);
        rchk(2'h1, 8'h7f);
        bus(1'b1, 2'h0, 16'h5a5a);
        rchk(2'h0, 8'h5a);
        bus(1'b1, 2'h1, 16'ha500);
        rchk(2'h0, 8'h00);
        $display("done: registers");
    endtask

    task automatic t_interval();
        int t0;
        bus(1'b1, 2'h1, 16'ha520);
        bus(1'b1, 2'h0, 16'h5a00);
        t0 = cyc;
        wait_ev(1'b0, 600);
        check(32'(cyc - t0 >= 508 && cyc - t0 <= 518), 32'h1);
        check(overflow_out_n, 1'b1);
        bus(1'b1, 2'h1, 16'ha520);
        check(interval_irq, 1'b1);
        rchk(2'h2, 8'h1f);
        rchk(2'h1, 8'hb8);
        bus(1'b1, 2'h1, 16'ha520);
        @(negedge ref_clk);
        check(interval_irq, 1'b0);
        bus(1'b1, 2'h1, 16'ha500);
        rchk(2'h0, 8'h00);
        $display("done: interval");
    endtask

    // Tick spacing measured between two counter changes seen by polling
    task automatic t_rate();
        int d[6] = '{2, 64, 128, 512, 2048, 8192};
        logic [7:0] v;
        int t0;
        int k;
        t0 = 0;
        for (int c = 1; c < 6; c++)
        begin
            bus(1'b1, 2'h1, 16'ha500);
            bus(1'b1, 2'h1, {8'ha5, 5'h04, c[2:0]});
            bus(1'b0, 2'h0, 16'h0);
            for (int e = 0; e < 3; e++)
            begin
                v = rd[7:0];
                k = 0;
                while (rd[7:0] === v && k < 20000)
                begin
                    bus(1'b0, 2'h0, 16'h0);
                    k++;
                end
                if (e == 1)
                    t0 = cyc;
            end
            check(32'(cyc - t0 >= d[c] - 3 && cyc - t0 <= d[c] + 3), 32'h1);
        end
        $display("done: prescaler");
    endtask

    task automatic t_watchdog(input logic chip_reset_enable);
        int lo;
        int hi;
        lo = 0;
        hi = 0;
        bus(1'b1, 2'h2, {8'h5a, 1'b0, chip_reset_enable, 6'h0});
        bus(1'b1, 2'h1, 16'ha520);
        bus(1'b1, 2'h0, 16'h5aff);
        wait_ev(1'b0, 40);
        // Leave the interval flag set so the overflow has to clear it
        bus(1'b1, 2'h1, 16'ha5e0);
        bus(1'b1, 2'h0, 16'h5aff);
        wait_ev(1'b1, 40);
        fork
            while (overflow_out_n === 1'b0)
            begin
                lo++;
                @(negedge ref_clk);
            end
            while (chip_reset_out === 1'b1)
            begin
                hi++;
                @(negedge ref_clk);
            end
            begin
                bus(1'b1, 2'h2, {8'h5a, 1'b0, ~chip_reset_enable, 6'h20});
                bus(1'b1, 2'h1, 16'ha520);
                bus(1'b0, 2'h2, 16'h0);
            end
        join
        check(lo, chip_reset_enable ? 132 : 130);
        check(hi, chip_reset_enable ? 518 : 0);
        check(interval_irq, 1'b0);
        bus(1'b1, 2'h2, 16'ha500);
        rchk(2'h2, {1'b1, chip_reset_enable, 6'h1f});
        bus(1'b1, 2'h2, 16'ha500);
        rchk(2'h2, {1'b0, chip_reset_enable, 6'h1f});
        rchk(2'h1, 8'h18);
        rchk(2'h0, 8'h00);
        $display("done: watchdog");
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_interval();
        t_rate();
        t_watchdog(1'b0);
        t_watchdog(1'b1);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        rchk(2'h2, 8'h1f);
        end_sim();
    end

    // Whole run needs about 34000 cycles; margin for a slow handshake
    initial
    begin
        repeat (80000) @(posedge ref_clk);
        check(32'h1, 32'h0);
        end_sim();
    end
endmodule // wdtit_top_test
